// ### hw/kbpu_pkg.sv
// kbpu_pkg: constants and state types for keyboard power-up and link logic
package kbpu_pkg;

    // clock periods
    localparam int SYS_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 30;
    localparam int NS_PER_MS = 1000000;
    localparam int NS_PER_US = 1000;
    localparam int SYS_CYC_PER_MS = NS_PER_MS / SYS_PERIOD_NS;

    // power-up timing, in milliseconds
    localparam int POR_MIN_MS = 150;
    localparam int POR_MAX_MS = 2000;
    localparam int SELF_TEST_MS = 100;
    localparam int SELF_TEST_MAX_MS = 500;
    localparam int CODE_POR_MS = 450;
    localparam int CODE_POR_MAX_MS = 2500;
    localparam int CODE_RST_MS = 500;

    // least times round up, longest times round down (both exact here)
    localparam int POR_MIN_CYC = POR_MIN_MS * SYS_CYC_PER_MS;
    localparam int POR_MAX_CYC = POR_MAX_MS * SYS_CYC_PER_MS;
    localparam int SELF_TEST_CYC = SELF_TEST_MS * SYS_CYC_PER_MS;
    localparam int SELF_TEST_MAX_CYC = SELF_TEST_MAX_MS * SYS_CYC_PER_MS;
    localparam int CODE_POR_CYC = CODE_POR_MS * SYS_CYC_PER_MS;
    localparam int CODE_POR_MAX_CYC = CODE_POR_MAX_MS * SYS_CYC_PER_MS;
    localparam int CODE_RST_CYC = CODE_RST_MS * SYS_CYC_PER_MS;

    // link timing, in microseconds, counted on the link clock
    localparam int HALF_BIT_US = 20;
    localparam int CHECK_MAX_US = 60;
    localparam int HALF_BIT_CYC = HALF_BIT_US * NS_PER_US / LINK_PERIOD_NS;
    localparam int CHECK_MAX_CYC = CHECK_MAX_US * NS_PER_US / LINK_PERIOD_NS;

    // frame layout and codes
    localparam logic [3:0] FRAME_BITS = 4'hb;
    localparam logic [3:0] INHIBIT_BIT = 4'ha;
    localparam logic [7:0] COMPLETE_CODE = 8'haa;
    localparam logic [1:0] CODE_SET_1 = 2'h1;
    localparam logic [1:0] CODE_SET_2 = 2'h2;

    // power-up sequencer states
    typedef enum logic [2:0] {
        PWR_POR,
        PWR_TEST,
        PWR_WAIT,
        PWR_IDLE,
        PWR_FAIL
    } kbpu_pwr_e;

    // link sender states
    typedef enum logic [1:0] {
        LNK_IDLE,
        LNK_SETUP,
        LNK_LOW,
        LNK_DONE
    } kbpu_lnk_e;

endpackage

// ### hw/kbpu_sync.sv
// kbpu_sync: flip-flop chain for crossings and pin inputs, optional filter
`timescale 1ns/10ps
module kbpu_sync #(
    parameter int STAGES = 3,
    parameter bit FILTER = 1'b1,
    parameter bit RST_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // data
    input wire logic d,
    output logic q
);

    typedef struct packed {
        logic [STAGES-1:0] sh;
        logic q;
    } kbpu_sync_s;

    kbpu_sync_s s;
    kbpu_sync_s next_s;

    if (STAGES < 2 || (FILTER && STAGES < 3)) begin : g_chk
        $error("kbpu_sync: too few stages");
    end

    // shift; filtered output follows once the last two stages agree
    always_comb begin
        next_s = s;
        next_s.sh = {s.sh[STAGES-2:0], d};
        if (!FILTER || s.sh[STAGES-1] == s.sh[STAGES-2]) begin
            next_s.q = s.sh[STAGES-1];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{sh: {STAGES{RST_VAL}}, q: RST_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign q = FILTER ? s.q : s.sh[STAGES-1];

endmodule // kbpu_sync

// ### hw/kbpu_timer.sv
// kbpu_timer: one-shot cycle counter, done after LIMIT cycles
`timescale 1ns/10ps
module kbpu_timer #(
    parameter int LIMIT = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    output logic done
);

    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } kbpu_tmr_s;

    kbpu_tmr_s s;
    kbpu_tmr_s next_s;

    if (LIMIT < 1) begin : g_chk
        $error("kbpu_timer: LIMIT must be at least 1");
    end

    // restart on start, else count up to the limit and hold
    always_comb begin
        next_s = s;
        if (start) begin
            next_s.cnt = '0;
            next_s.done = 1'b0;
        end else if (!s.done) begin
            next_s.cnt = s.cnt + W'(1);
            if (s.cnt == LAST) begin
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{cnt: '0, done: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;

endmodule // kbpu_timer

// ### hw/kbpu_top.sv
// kbpu_top: keyboard power-up, self-test and completion-code link sender
// Function
// - Power-on reset ends no earlier than 150 ms and no later than 2.0 s.
// - Indicators go on when the self-test starts and off when it ends.
// - A passing self-test sends the completion byte aah to the host.
// - The self-test lasts at most 500 ms and ignores both link lines.
// - Code sent within 450 ms of power-on (2.5 s max), 500 ms of a reset.
// - Code goes 11-bit; no inhibit after bit ten keeps 11-bit and set 2.
// - A host inhibit in that frame selects the short format and code set 1.
// - Both lines are only pulled low or released, and released when idle.
// - The keyboard makes every clock pulse on the clock line.
// - While inhibited, clock-line levels are not taken as transfer clocks.
// - Long frame: low start, 8 data bits lsb first, odd parity, high stop.
// - A short frame is a low test bit, a high start bit and eight data bits; the code never sends one, it only sets frame_short.
// - Clock checked high at least every 60 us; a low clock at any check up to clock eleven aborts the frame.
`timescale 1ns/10ps
module kbpu_top #(
    parameter int POR_CYC = kbpu_pkg::POR_MIN_CYC,
    parameter int TEST_CYC = kbpu_pkg::SELF_TEST_CYC,
    parameter int HALF_CYC = kbpu_pkg::HALF_BIT_CYC,
    parameter int LED_W = 3
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // link clock
    input wire logic link_clk,
    // open-collector clock line
    input wire logic kbd_clk_in,
    output logic kbd_clk_out,
    output logic kbd_clk_oe,
    // open-collector data line
    input wire logic kbd_data_in,
    output logic kbd_data_out,
    output logic kbd_data_oe,
    // keyboard core side
    input wire logic reset_cmd,
    input wire logic self_test_pass,
    output logic [LED_W-1:0] leds,
    output logic self_test_busy,
    output logic self_test_fail,
    output logic code_sent,
    output logic frame_short,
    output logic [1:0] code_set,
    output logic host_send_req
);

    localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

    if (POR_CYC < 1 || TEST_CYC < 1 || HALF_CYC < 8 || HALF_CYC > 65535
        || LED_W < 1) begin : g_chk
        $error("kbpu_top: parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // resets and crossings

    logic rst_n;
    logic link_rst_n;
    logic clk_s;
    logic data_s;
    logic start_sync;
    logic done_sync;
    logic inh_sync;
    logic rts_sync;
    logic por_done;
    logic test_done;

    typedef struct packed {
        kbpu_pkg::kbpu_pwr_e state;
        logic test_start;
        logic leds_on;
        logic fail;
        logic start_tgl;
        logic done_seen;
        logic frame_short;
        logic [1:0] code_set;
        logic code_sent;
        logic by_cmd;
        logic [31:0] since_rst;
        logic [31:0] test_len;
    } kbpu_sys_s;

    typedef struct packed {
        kbpu_pkg::kbpu_lnk_e state;
        logic [15:0] cnt;
        logic [3:0] idx;
        logic [10:0] frame;
        logic clk_oe;
        logic data_oe;
        logic inhibit;
        logic start_seen;
        logic done_tgl;
        logic rts;
        logic [15:0] since_chk;
    } kbpu_lnk_s;

    kbpu_sys_s s;
    kbpu_sys_s next_s;
    kbpu_lnk_s l;
    kbpu_lnk_s next_l;

    // reset release, two flops per domain
    kbpu_sync #(.STAGES(2), .FILTER(1'b0), .RST_VAL(1'b0)) u_rst_sys (
        .clk(sys_clk), .arst_n(nrst), .d(1'b1), .q(rst_n));
    kbpu_sync #(.STAGES(2), .FILTER(1'b0), .RST_VAL(1'b0)) u_rst_lnk (
        .clk(link_clk), .arst_n(nrst), .d(1'b1), .q(link_rst_n));

    // pin inputs, filtered, released lines read high
    kbpu_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b1)) u_clk_pin (
        .clk(link_clk), .arst_n(link_rst_n), .d(kbd_clk_in), .q(clk_s));
    kbpu_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b1)) u_data_pin (
        .clk(link_clk), .arst_n(link_rst_n), .d(kbd_data_in), .q(data_s));

    // send request toggle into the link domain
    kbpu_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b0)) u_start_x (
        .clk(link_clk), .arst_n(link_rst_n), .d(s.start_tgl),
        .q(start_sync));

    // frame result and host request back to the system domain
    kbpu_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b0)) u_done_x (
        .clk(sys_clk), .arst_n(rst_n), .d(l.done_tgl), .q(done_sync));
    kbpu_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b0)) u_inh_x (
        .clk(sys_clk), .arst_n(rst_n), .d(l.inhibit), .q(inh_sync));
    kbpu_sync #(.STAGES(3), .FILTER(1'b1), .RST_VAL(1'b0)) u_rts_x (
        .clk(sys_clk), .arst_n(rst_n), .d(l.rts), .q(rts_sync));

    // power-on and self-test windows on the own clock
    kbpu_timer #(.LIMIT(POR_CYC)) u_por_tmr (
        .clk(sys_clk), .rst_n(rst_n), .start(1'b0), .done(por_done));
    kbpu_timer #(.LIMIT(TEST_CYC)) u_test_tmr (
        .clk(sys_clk), .rst_n(rst_n), .start(s.test_start),
        .done(test_done));

    ////////////////////////////////////////////////////////////////////////
    // power-up sequencer, system clock

    // por window, self-test, completion code, autoselect result
    always_comb begin
        next_s = s;
        next_s.test_start = 1'b0;
        if (s.since_rst != 32'hffffffff) begin
            next_s.since_rst = s.since_rst + 32'h1;
        end
        next_s.test_len = '0;
        unique case (s.state)
            kbpu_pkg::PWR_POR: begin
                if (por_done) begin
                    next_s.state = kbpu_pkg::PWR_TEST;
                    next_s.leds_on = 1'b1;
                    next_s.test_start = 1'b1;
                end
            end
            kbpu_pkg::PWR_TEST: begin
                // link lines are not looked at here
                next_s.test_len = s.test_len + 32'h1;
                if (test_done && !s.test_start) begin
                    next_s.leds_on = 1'b0;
                    if (self_test_pass) begin
                        next_s.state = kbpu_pkg::PWR_WAIT;
                        next_s.start_tgl = ~s.start_tgl;
                    end else begin
                        next_s.state = kbpu_pkg::PWR_FAIL;
                        next_s.fail = 1'b1;
                    end
                end
            end
            kbpu_pkg::PWR_WAIT: begin
                if (done_sync != s.done_seen) begin
                    next_s.done_seen = done_sync;
                    next_s.frame_short = inh_sync;
                    next_s.code_set = inh_sync ? kbpu_pkg::CODE_SET_1
                                               : kbpu_pkg::CODE_SET_2;
                    next_s.code_sent = 1'b1;
                    next_s.state = kbpu_pkg::PWR_IDLE;
                end
            end
            kbpu_pkg::PWR_IDLE, kbpu_pkg::PWR_FAIL: begin
                if (reset_cmd) begin
                    next_s.state = kbpu_pkg::PWR_TEST;
                    next_s.leds_on = 1'b1;
                    next_s.test_start = 1'b1;
                    next_s.fail = 1'b0;
                    next_s.code_sent = 1'b0;
                    next_s.by_cmd = 1'b1;
                    next_s.since_rst = '0;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{state: kbpu_pkg::PWR_POR, default: '0};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame sender, link clock

    // bit timing: released half, then clock pulled low half
    always_comb begin
        next_l = l;
        next_l.cnt = l.cnt + 16'h1;
        next_l.since_chk = l.since_chk + 16'h1;
        next_l.rts = 1'b0;
        unique case (l.state)
            kbpu_pkg::LNK_IDLE: begin
                next_l.cnt = '0;
                next_l.since_chk = '0;
                next_l.clk_oe = 1'b0;
                next_l.data_oe = 1'b0;
                next_l.rts = ~data_s;
                // no start while clock held low or host wants to send
                if (start_sync != l.start_seen && clk_s && data_s) begin
                    next_l.start_seen = start_sync;
                    next_l.frame = {1'b1, ~^kbpu_pkg::COMPLETE_CODE,
                        kbpu_pkg::COMPLETE_CODE, 1'b0};
                    next_l.idx = '0;
                    next_l.inhibit = 1'b0;
                    next_l.data_oe = 1'b1; // start bit low
                    next_l.state = kbpu_pkg::LNK_SETUP;
                end
            end
            kbpu_pkg::LNK_SETUP: begin
                if (l.cnt == HALF_LAST) begin
                    next_l.cnt = '0;
                    next_l.since_chk = '0;
                    // clock must read high once released
                    if (!clk_s) begin
                        // at any bit, not only after bit ten, this ends the frame and marks autoselect
                        next_l.inhibit = 1'b1;
                        next_l.data_oe = 1'b0;
                        next_l.state = kbpu_pkg::LNK_DONE;
                    end else begin
                        next_l.clk_oe = 1'b1;
                        next_l.state = kbpu_pkg::LNK_LOW;
                    end
                end
            end
            kbpu_pkg::LNK_LOW: begin
                if (l.cnt == HALF_LAST) begin
                    next_l.cnt = '0;
                    next_l.clk_oe = 1'b0;
                    next_l.idx = l.idx + 4'h1;
                    if (l.idx == kbpu_pkg::FRAME_BITS - 4'h1) begin
                        next_l.data_oe = 1'b0;
                        next_l.state = kbpu_pkg::LNK_DONE;
                    end else begin
                        next_l.frame = {1'b0, l.frame[10:1]};
                        next_l.data_oe = ~l.frame[1];
                        next_l.state = kbpu_pkg::LNK_SETUP;
                    end
                end
            end
            kbpu_pkg::LNK_DONE: begin
                // lines released, result settles before the toggle
                next_l.since_chk = '0;
                next_l.clk_oe = 1'b0;
                next_l.data_oe = 1'b0;
                if (l.cnt == HALF_LAST) begin
                    next_l.done_tgl = ~l.done_tgl;
                    next_l.state = kbpu_pkg::LNK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l <= '{state: kbpu_pkg::LNK_IDLE, default: '0};
        end else begin
            l <= next_l;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign kbd_clk_out = 1'b0; // open collector: low or released
    assign kbd_data_out = 1'b0;
    assign kbd_clk_oe = l.clk_oe;
    assign kbd_data_oe = l.data_oe;
    assign leds = {LED_W{s.leds_on}};
    assign self_test_busy = (s.state == kbpu_pkg::PWR_TEST);
    assign self_test_fail = s.fail;
    assign code_sent = s.code_sent;
    assign frame_short = s.frame_short;
    assign code_set = s.code_set;
    assign host_send_req = rts_sync;

    ////////////////////////////////////////////////////////////////////////
    // checks, system clock

    sequence s_test_start;
        $rose(self_test_busy);
    endsequence

    sequence s_test_end;
        $fell(self_test_busy);
    endsequence

    property p_por_window;
        @(posedge sys_clk) disable iff (!rst_n)
        s_test_start ##0 $past(s.state) == kbpu_pkg::PWR_POR
        |-> s.since_rst >= POR_CYC && s.since_rst <= kbpu_pkg::POR_MAX_CYC;
    endproperty
    a_por_window: assert property (p_por_window)
        else $error("por window out of range");

    property p_leds_on;
        @(posedge sys_clk) disable iff (!rst_n)
        s_test_start |-> leds == {LED_W{1'b1}};
    endproperty
    a_leds_on: assert property (p_leds_on)
        else $error("indicators not on at test start");

    property p_leds_off;
        @(posedge sys_clk) disable iff (!rst_n)
        s_test_end |-> leds == '0;
    endproperty
    a_leds_off: assert property (p_leds_off)
        else $error("indicators not off at test end");

    property p_code_on_pass;
        @(posedge sys_clk) disable iff (!rst_n)
        s_test_end ##0 $changed(s.start_tgl) |-> $past(self_test_pass);
    endproperty
    a_code_on_pass: assert property (p_code_on_pass)
        else $error("completion code sent without pass");

    property p_test_len;
        @(posedge sys_clk) disable iff (!rst_n)
        self_test_busy |-> s.test_len <= kbpu_pkg::SELF_TEST_MAX_CYC;
    endproperty
    a_test_len: assert property (p_test_len)
        else $error("self-test too long");

    property p_code_deadline;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(code_sent) |-> s.since_rst <= (s.by_cmd
            ? kbpu_pkg::CODE_RST_CYC : kbpu_pkg::CODE_POR_MAX_CYC);
    endproperty
    a_code_deadline: assert property (p_code_deadline)
        else $error("completion code late");

    property p_keep_long;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(code_sent) && !inh_sync |-> !frame_short
            && code_set == kbpu_pkg::CODE_SET_2;
    endproperty
    a_keep_long: assert property (p_keep_long)
        else $error("long format not kept");

    property p_go_short;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(code_sent) && inh_sync |-> frame_short
            && code_set == kbpu_pkg::CODE_SET_1;
    endproperty
    a_go_short: assert property (p_go_short)
        else $error("short format not selected");

    ////////////////////////////////////////////////////////////////////////
    // checks, link clock

    property p_idle_released;
        @(posedge link_clk) disable iff (!link_rst_n)
        l.state == kbpu_pkg::LNK_IDLE |-> !kbd_clk_oe && !kbd_data_oe;
    endproperty
    a_idle_released: assert property (p_idle_released)
        else $error("line driven while idle");

    property p_clk_pulse;
        @(posedge link_clk) disable iff (!link_rst_n)
        $rose(kbd_clk_oe) |-> kbd_clk_oe [*8];
    endproperty
    a_clk_pulse: assert property (p_clk_pulse)
        else $error("clock pulse too short");

    property p_no_start_inhibited;
        @(posedge link_clk) disable iff (!link_rst_n)
        l.state == kbpu_pkg::LNK_IDLE && !clk_s
        |=> l.state == kbpu_pkg::LNK_IDLE;
    endproperty
    a_no_start_inhibited: assert property (p_no_start_inhibited)
        else $error("frame started while inhibited");

    property p_check_rate;
        @(posedge link_clk) disable iff (!link_rst_n)
        l.state != kbpu_pkg::LNK_IDLE
        |-> l.since_chk <= kbpu_pkg::CHECK_MAX_CYC;
    endproperty
    a_check_rate: assert property (p_check_rate)
        else $error("clock line not checked in time");

endmodule // kbpu_top

// ### test/kbpu_host.sv
// kbpu_host: behavioural host controller on the clock and data lines
`timescale 1ns/10ps
module kbpu_host (
    // keyboard pull-down enables
    input wire logic kbd_clk_oe,
    input wire logic kbd_data_oe,
    // host behaviour controls
    input wire logic inhibit,
    input wire logic send_req,
    input wire logic clr,
    // resolved wire levels
    output logic clk_line,
    output logic data_line,
    // captured frame
    output logic [10:0] bits,
    output logic [3:0] nbits
);
    // open-collector wires with pull-ups, host pulls only low
    assign clk_line = !(kbd_clk_oe || inhibit);
    assign data_line = !(kbd_data_oe || send_req);
    // take each bit as the keyboard pulls the clock low, inhibited or not
    always @(posedge kbd_clk_oe or posedge clr) begin
        if (clr) begin
            nbits <= 4'h0;
        end else begin
            bits[nbits] <= data_line;
            nbits <= nbits + 4'h1;
        end
    end
endmodule // kbpu_host

// ### test/keyboard_link_power_up_tb.sv
// keyboard_link_power_up_tb: power-up, self-test and autoselect bench
`timescale 1ns/10ps
module keyboard_link_power_up_tb;
    localparam int POR = 200;
    localparam int TST = 100;
    logic sys_clk = 0, link_clk = 0, nrst = 0, reset_cmd = 0, pass = 1;
    logic inh = 0, req = 0, clr = 0, kc_o, kd_o, kc_oe, kd_oe;
    logic busy, tfail, sent, fshort, hsr, clk_line, data_line;
    logic [2:0] leds;
    logic [1:0] cset;
    logic [10:0] bits;
    logic [3:0] nbits;
    int fail_count = 0, n_compared = 0, cyc = 0, t, k;
    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    kbpu_top #(.POR_CYC(POR), .TEST_CYC(TST), .HALF_CYC(16)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .link_clk(link_clk),
        .kbd_clk_in(clk_line), .kbd_clk_out(kc_o), .kbd_clk_oe(kc_oe),
        .kbd_data_in(data_line), .kbd_data_out(kd_o), .kbd_data_oe(kd_oe),
        .reset_cmd(reset_cmd), .self_test_pass(pass), .leds(leds),
        .self_test_busy(busy), .self_test_fail(tfail), .code_sent(sent),
        .frame_short(fshort), .code_set(cset), .host_send_req(hsr));
    kbpu_host host (.kbd_clk_oe(kc_oe), .kbd_data_oe(kd_oe), .inhibit(inh),
        .send_req(req), .clr(clr), .clk_line(clk_line),
        .data_line(data_line), .bits(bits), .nbits(nbits));
    // expected long frame: start, data lsb first, odd parity, stop
    function automatic logic [10:0] frame_of(input logic [7:0] b);
        return {1'b1, ~^b, b, 1'b0};
    endfunction
    task automatic check(input logic [31:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            give_verdict();
        end
    end
    // reset command pulse, then the test window with line noise
    task automatic restart;
        clr = 1;
        #1 clr = 0;
        @(posedge sys_clk) #2 reset_cmd = 1;
        @(posedge sys_clk) #2 reset_cmd = 0;
    endtask
    task automatic test_phase;
        check(leds, 3'h7, "leds not on in test");
        // line noise, lines idle again at the last step
        for (int i = 0; i < TST / 2; i++) begin
            @(posedge sys_clk) #2;
            {inh, req} = (i < TST / 2 - 1) ? 2'($urandom) : 2'h0;
        end
        t = 0;
        while (busy !== 1'b0 && t < 2000) begin
            @(posedge sys_clk) #2;
            t++;
        end
        check(t <= TST / 2 + 2, 1, "test too long");
        check(leds, 3'h0, "leds not off after test");
    endtask
    task automatic wait_sent;
        t = 0;
        while (sent !== 1'b1 && t < 3000) begin
            @(posedge sys_clk) #2;
            t++;
        end
        check(sent, 1, "no completion code");
        check({kc_oe, kd_oe}, 2'h0, "lines not released");
        check({kc_o, kd_o}, 2'h0, "lines driven high");
    endtask
    initial begin
        t = $urandom(39638);
        #1 clr = 1;
        repeat (4) @(posedge sys_clk);
        #2 nrst = 1;
        clr = 0;
        t = 0;
        while (busy !== 1'b1 && t < 2000) begin
            @(posedge sys_clk) #2;
            t++;
        end
        check(t >= POR && t <= POR + 4, 1, "por window");
        test_phase();
        wait_sent();
        check(nbits, 4'hb, "frame length");
        check(bits, frame_of(8'haa), "frame content");
        check({fshort, cset}, 3'h2, "long format set 2");
        // idle host request on the data line
        req = 1;
        repeat (12) @(posedge sys_clk);
        #2;
        check(hsr, 1, "send request not seen");
        req = 0;
        repeat (12) @(posedge sys_clk);
        #2;
        check(hsr, 0, "send request stuck");
        // host inhibits during the completion frame at several bits
        for (int i = 0; i < 3; i++) begin
            k = (i == 0) ? 10 : (i == 1) ? 1 : 2 + $urandom_range(7);
            restart();
            test_phase();
            t = 0;
            while (nbits < k[3:0] && t < 3000) begin
                @(posedge sys_clk) #2;
                t++;
            end
            inh = 1;
            wait_sent();
            check({fshort, cset}, 3'h5, "short set 1");
            check(nbits, k, "clock edges while inhibited");
            inh = 0;
        end
        // failing self-test sends nothing
        pass = 0;
        restart();
        repeat (TST + 40) @(posedge sys_clk);
        #2;
        check({tfail, sent, nbits}, 6'h20, "fail path");
        // reset command taken from the fail state
        pass = 1;
        restart();
        test_phase();
        wait_sent();
        check({tfail, fshort, cset}, 4'h2, "recovery from fail");
        give_verdict();
    end
endmodule // keyboard_link_power_up_tb
